// File: wdt_pkg.sv
package wdt_pkg;

  // ************************************************************
  // register map (byte addresses on the bus)
  // ************************************************************
  localparam logic [3:0] OFS_COUNT = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h4;
  localparam logic [3:0] OFS_EVENT = 4'h8;

  localparam logic [7:0] KEY_COUNT = 8'h5a;
  localparam logic [7:0] KEY_CTRL = 8'ha5;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ************************************************************
  // control/status field positions
  // ************************************************************
  localparam int BIT_ENABLE = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_RSTKIND = 5;
  localparam int BIT_WATCHDOG_OVERFLOW_FLAG = 4;
  localparam int BIT_INTERVAL_OVERFLOW_FLAG = 3;
  localparam int CKS_MSB = 2;
  localparam int CKS_LSB = 0;

  // smallest division is 1/32 = 2**5
  localparam int DIV_BASE_LOG2 = 5;
  localparam int PRESCALE_W = 12;

  // width of a reset pulse driven to the reset logic, in cycles
  localparam logic [3:0] RESET_PULSE_CYCLES = 4'h8;

  // byte-enable pattern of a 16-bit write in the low half word
  localparam logic [3:0] SEL_HALF = 4'h3;

  typedef struct packed {
    logic enable;
    logic watchdog_mode;
    logic reset_kind_select;
    logic watchdog_overflow_flag;
    logic interval_overflow_flag;
    logic [2:0] clock_select;
  } ctrl_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STANDBY = 2'b01,
    ST_STABILISE = 2'b10
  } wdt_state_e;

endpackage

// File: watchdog_interval_timer.sv
// Our own choices: the address map and the Wishbone slave port.
`timescale 1ns/100ps

// Function
// - 8-bit counter counts selected ticks when enabled
// - overflow gives reset or interrupt by mode
// - counter cleared only by power-on reset pin
// - control cleared only by power-on reset
// - counter write needs 16 bits, key 5a
// - control write needs 16 bits, key a5
// - bit 7 gates counting, else hold value
// - bit 6 selects interval or watchdog mode
// - bit 5 picks power-on or manual reset
// - bit 4 set on watchdog overflow only
// - bit 3 set on interval overflow only
// - bits 2..0 pick divide 32 to 4096
// - standby counting starts on interrupt wakeup
// - frequency change stops clock, starts stabilisation
// - stabilisation overflow resumes clock, flags untouched
// - counter stops at 00 after stabilisation; keeps counting if bit 7 set
// - watchdog overflow flags, resets, keeps counting
// - interval overflow flags, interrupts, keeps counting
module watchdog_interval_timer #(
  parameter int COUNT_W = 8
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic POWER_ON_RESET_PIN,
  input wire logic DIVIDER_TICK,
  input wire logic STANDBY_ENTER,
  input wire logic FREQ_CHANGE,
  input wire logic WAKEUP_EVENT,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic CLOCK_STOP,
  output logic POWER_ON_RESET_REQ,
  output logic MANUAL_RESET_REQ,
  output logic INTERVAL_IRQ
);

  // ************************************************************
  // local sizes
  // ************************************************************
  // one clock select code per division step, 1/32 up to 1/4096
  localparam int NUM_CODES = 8;
  // reset request counter: idle value and last pulse cycle
  localparam logic [3:0] PULSE_IDLE = 4'h0;
  localparam logic [3:0] PULSE_LAST = 4'h1;

  // ************************************************************
  // input synchronisers for pins from outside this domain
  // ************************************************************
  logic [1:0] por_sync_ff;
  logic [1:0] wake_sync_ff;
  logic por_pin;
  logic wake_pin;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      por_sync_ff <= 2'b00;
      wake_sync_ff <= 2'b00;
    end else begin
      por_sync_ff <= {por_sync_ff[0], POWER_ON_RESET_PIN};
      wake_sync_ff <= {wake_sync_ff[0], WAKEUP_EVENT};
    end
  end

  // pins idle low, so cleared stages raise no false event after reset
  assign por_pin = por_sync_ff[1];
  assign wake_pin = wake_sync_ff[1];

  // ************************************************************
  // bus slave: single-cycle ack, one wait free
  // ************************************************************
  logic ack_ff;
  logic bus_req;
  logic wr_half;
  logic wr_count;
  logic wr_ctrl;
  logic [7:0] wr_key;
  logic [7:0] wr_byte;
  logic hit_count;
  logic hit_ctrl;
  logic key_count_ok;
  logic key_ctrl_ok;

  assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
  assign wr_half = bus_req && WB_WE_I && (WB_SEL_I == wdt_pkg::SEL_HALF);
  assign wr_key = WB_DAT_I[15:8];
  assign wr_byte = WB_DAT_I[7:0];
  assign hit_count = (WB_ADR_I == wdt_pkg::OFS_COUNT);
  assign hit_ctrl = (WB_ADR_I == wdt_pkg::OFS_CTRL);
  assign key_count_ok = (wr_key == wdt_pkg::KEY_COUNT);
  assign key_ctrl_ok = (wr_key == wdt_pkg::KEY_CTRL);
  // a byte or word-wide write or a wrong key is dropped but still acked
  assign wr_count = wr_half && hit_count && key_count_ok;
  assign wr_ctrl = wr_half && hit_ctrl && key_ctrl_ok;

  // writes land at the taking edge, the same edge that raises ack

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  assign WB_ACK_O = ack_ff;

  // ************************************************************
  // prescaler and tick select
  // ************************************************************
  logic [wdt_pkg::PRESCALE_W-1:0] prescale_ff;
  logic [wdt_pkg::PRESCALE_W-1:0] nxt_prescale;
  logic count_tick;
  logic [NUM_CODES-1:0] tick_by_code;
  wdt_pkg::ctrl_s ctrl_ff;
  wdt_pkg::wdt_state_e state_ff;
  logic counting;

  assign nxt_prescale = prescale_ff + {{(wdt_pkg::PRESCALE_W-1){1'b0}}, 1'b1};

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prescale_ff <= '0;
    end else if (DIVIDER_TICK && counting) begin
      prescale_ff <= nxt_prescale;
    end
  end

  // tick on the all-ones wrap of the low 5+code bits: divide by 2**(5+code)
  for (genvar g = 0; g < NUM_CODES; g = g + 1) begin : g_tick
    localparam int TOP = wdt_pkg::DIV_BASE_LOG2 + g - 1;
    assign tick_by_code[g] = &prescale_ff[TOP:0];
  end

  // prescaler only runs while counting, so a halted timer resumes mid-step
  assign count_tick = DIVIDER_TICK && counting && tick_by_code[ctrl_ff.clock_select];

  // ************************************************************
  // stabilisation state machine
  // ************************************************************
  logic overflow;
  logic [COUNT_W-1:0] count_ff;


  // ************************************************************
  // count gating
  // ************************************************************
  // stabilisation counts whatever the enable bit says; standby never counts
  always_comb begin
    case (state_ff)
      wdt_pkg::ST_RUN: begin
        counting = ctrl_ff.enable;
      end
      wdt_pkg::ST_STABILISE: begin
        counting = 1'b1;
      end
      default: begin
        counting = 1'b0;
      end
    endcase
  end

  assign overflow = count_tick && (&count_ff);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_ff <= wdt_pkg::ST_RUN;
    end else begin
      case (state_ff)
        wdt_pkg::ST_RUN: begin
          // a frequency change wins over a same-cycle standby request
          if (FREQ_CHANGE) begin
            state_ff <= wdt_pkg::ST_STABILISE;
          end else if (STANDBY_ENTER) begin
            state_ff <= wdt_pkg::ST_STANDBY;
          end
        end
        wdt_pkg::ST_STANDBY: begin
          if (wake_pin) begin
            state_ff <= wdt_pkg::ST_STABILISE;
          end
        end
        wdt_pkg::ST_STABILISE: begin
          if (overflow) begin
            state_ff <= wdt_pkg::ST_RUN;
          end
        end
        default: begin
          state_ff <= wdt_pkg::ST_RUN;
        end
      endcase
    end
  end

  // high in standby and while stabilising; the far side gates its clock
  assign CLOCK_STOP = (state_ff != wdt_pkg::ST_RUN);

  // ************************************************************
  // counter
  // ************************************************************
  // the async reset only seeds a value; the pin clears it synchronously
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      count_ff <= COUNT_W'(wdt_pkg::COUNT_RESET);
    end else if (por_pin) begin
      count_ff <= COUNT_W'(wdt_pkg::COUNT_RESET);
      // a keyed write beats a same-cycle tick
    end else if (wr_count) begin
      count_ff <= COUNT_W'(wr_byte);
    end else if (count_tick) begin
      count_ff <= count_ff + {{(COUNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ************************************************************
  // control/status register
  // ************************************************************
  logic run_ovf;
  logic wd_ovf;
  logic it_ovf;

  // stabilisation overflow never sets a flag
  assign run_ovf = overflow && (state_ff == wdt_pkg::ST_RUN);
  assign wd_ovf = run_ovf && ctrl_ff.watchdog_mode;
  assign it_ovf = run_ovf && !ctrl_ff.watchdog_mode;

  // kept through its own watchdog reset: only the pin clears it
  // mode and clock select are taken as written even while running
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      ctrl_ff <= wdt_pkg::ctrl_s'(wdt_pkg::CTRL_RESET);
    end else if (por_pin) begin
      ctrl_ff <= wdt_pkg::ctrl_s'(wdt_pkg::CTRL_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wdt_pkg::ctrl_s'(wr_byte);
      end
      // set wins over a same-cycle software clear
      if (wd_ovf) begin
        ctrl_ff.watchdog_overflow_flag <= 1'b1;
      end
      if (it_ovf) begin
        ctrl_ff.interval_overflow_flag <= 1'b1;
      end
    end
  end

  // ************************************************************
  // reset and interrupt outputs
  // ************************************************************
  logic [3:0] rst_cnt_ff;
  logic por_req_ff;
  logic manual_req_ff;
  logic irq_ff;

  // pulse length; a fresh overflow mid-pulse starts it again
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rst_cnt_ff <= PULSE_IDLE;
    end else if (wd_ovf) begin
      rst_cnt_ff <= wdt_pkg::RESET_PULSE_CYCLES;
    end else if (rst_cnt_ff != PULSE_IDLE) begin
      rst_cnt_ff <= rst_cnt_ff - 4'h1;
    end
  end

  // requests come from flops: a decoded one could glitch the reset logic
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      por_req_ff <= 1'b0;
      manual_req_ff <= 1'b0;
    end else if (wd_ovf) begin
      por_req_ff <= !ctrl_ff.reset_kind_select;
      manual_req_ff <= ctrl_ff.reset_kind_select;
    end else if (rst_cnt_ff == PULSE_LAST) begin
      por_req_ff <= 1'b0;
      manual_req_ff <= 1'b0;
    end
  end

  // ************************************************************
  // interval interrupt
  // ************************************************************
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= it_ovf;
    end
  end

  assign POWER_ON_RESET_REQ = por_req_ff;
  assign MANUAL_RESET_REQ = manual_req_ff;
  assign INTERVAL_IRQ = irq_ff;

  // ************************************************************
  // read data
  // ************************************************************
  logic [7:0] rd_byte;
  logic rd_req;

  assign rd_req = bus_req && !WB_WE_I;

  // unmapped reads return zero; only the low byte lane carries data
  always_comb begin
    case (WB_ADR_I)
      wdt_pkg::OFS_COUNT: begin
        rd_byte = 8'(count_ff);
      end
      wdt_pkg::OFS_CTRL: begin
        rd_byte = ctrl_ff;
      end
      wdt_pkg::OFS_EVENT: begin
        rd_byte = {6'h00, state_ff};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // captured at the taking edge, stands until the next read
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (rd_req) begin
      WB_DAT_O <= {24'h00_0000, rd_byte};
    end
  end

endmodule // watchdog_interval_timer

// File: divider_tick_model.sv
`timescale 1ns/100ps
module divider_tick_model #(
  parameter int PERIOD = 2
) (
  input wire logic clock,
  input wire logic rst,
  output logic tick
);
  // ****
  // divider input as a one-cycle enable
  // ****
  int cnt_ff;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_ff <= 0;
    end else begin
      cnt_ff <= (cnt_ff + 1) % PERIOD;
    end
  end
  assign tick = (cnt_ff == PERIOD - 1);
endmodule // divider_tick_model

// File: watchdog_interval_timer_sva.sv
`timescale 1ns/100ps
module wit_checker (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic POWER_ON_RESET_REQ,
  input wire logic MANUAL_RESET_REQ,
  input wire logic INTERVAL_IRQ
);
  // ****
  // port relations
  // ****
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  property p_take; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
  a_take: assert property (p_take) else $error("request not acked");
  property p_ack; WB_ACK_O |=> !WB_ACK_O; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than one cycle");
  property p_rd; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0; endproperty
  a_rd: assert property (p_rd) else $error("read upper bits set");
  property p_irq; INTERVAL_IRQ |=> !INTERVAL_IRQ; endproperty
  a_irq: assert property (p_irq) else $error("interrupt not a pulse");
  property p_por;
    $rose(POWER_ON_RESET_REQ) |-> POWER_ON_RESET_REQ [*8] ##1 !POWER_ON_RESET_REQ;
  endproperty
  a_por: assert property (p_por) else $error("power-on request length");
  property p_mrr;
    $rose(MANUAL_RESET_REQ) |-> MANUAL_RESET_REQ [*8] ##1 !MANUAL_RESET_REQ;
  endproperty
  a_mrr: assert property (p_mrr) else $error("manual request length");
  property p_one; !(POWER_ON_RESET_REQ && MANUAL_RESET_REQ); endproperty
  a_one: assert property (p_one) else $error("both reset kinds");
  property p_kind;
    INTERVAL_IRQ |-> !$rose(POWER_ON_RESET_REQ) && !$rose(MANUAL_RESET_REQ);
  endproperty
  a_kind: assert property (p_kind) else $error("reset with interrupt");
  cover property (INTERVAL_IRQ);
  cover property ($rose(POWER_ON_RESET_REQ));
  cover property ($rose(MANUAL_RESET_REQ));
endmodule // wit_checker
bind watchdog_interval_timer wit_checker u_chk (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .POWER_ON_RESET_REQ(POWER_ON_RESET_REQ), .MANUAL_RESET_REQ(MANUAL_RESET_REQ),
  .INTERVAL_IRQ(INTERVAL_IRQ));

// File: watchdog_interval_timer_bench.sv
`timescale 1ns/100ps
module watchdog_interval_timer_bench;
  typedef struct {logic [3:0] a, s; logic [15:0] d; logic [7:0] e;} row_s;
  logic clk = 1'b0;
  logic rst, pin, tick, stby, frq, wake, cyc, stb, we, ack, cstop, por, mrr, irq;
  logic [3:0] adr, sel;
  logic [31:0] dat, dato;
  logic [7:0] q;
  int error_cnt, num_checks, cycles, n;
  // ****
  // keyed writes, byte read-back, counting halted
  // ****
  row_s rows[7] = '{'{4'h4, 4'h3, 16'ha507, 8'h07}, '{4'h4, 4'h3, 16'h5a01, 8'h07},
    '{4'h4, 4'hf, 16'ha501, 8'h07}, '{4'h0, 4'h3, 16'h5a34, 8'h34},
    '{4'h0, 4'h3, 16'ha555, 8'h34}, '{4'h0, 4'h1, 16'h5a55, 8'h34},
    '{4'hc, 4'h3, 16'h5a55, 8'h00}};
  watchdog_interval_timer u_dut (.CLOCK(clk), .RST(rst), .POWER_ON_RESET_PIN(pin),
    .DIVIDER_TICK(tick), .STANDBY_ENTER(stby), .FREQ_CHANGE(frq), .WAKEUP_EVENT(wake),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dat), .WB_DAT_O(dato), .WB_ACK_O(ack), .CLOCK_STOP(cstop),
    .POWER_ON_RESET_REQ(por), .MANUAL_RESET_REQ(mrr), .INTERVAL_IRQ(irq));
  divider_tick_model #(.PERIOD(2)) u_tick (.clock(clk), .rst(rst), .tick(tick));
  always #12.5 clk = ~clk;
  task automatic test_done;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic [3:0] a, s, input logic [15:0] d, input logic w);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {16'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    wb(a, 4'h1, 16'h0, 1'b0);
    chk(nm, e, q);
  endtask
  task automatic waitfor(ref logic s, input logic v);
    n = 0;
    while (s !== v && n < 30000) begin
      @(posedge clk);
      n++;
    end
  endtask
  initial begin
    rst = 1'b1;
    {pin, stby, frq, wake, cyc, stb, we} = 7'h0;
    {adr, sel, dat} = 40'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) begin
      wb(rows[i].a, rows[i].s, rows[i].d, 1'b1);
      rdchk("row", rows[i].a, rows[i].e);
    end
    repeat (300) @(posedge clk);
    rdchk("held", 4'h0, 8'h34);
    // count from fd: three ticks of 2**(5+k) divider enables
    for (int k = 0; k < 8; k++) begin
      wb(4'h4, 4'h3, 16'ha500, 1'b1);
      wb(4'h0, 4'h3, 16'h5afd, 1'b1);
      wb(4'h4, 4'h3, {13'h14b0, k[2:0]}, 1'b1);
      waitfor(irq, 1'b1);
      chk("period", 8'h1, 8'(n >= (128 << k) - 8 && n <= (192 << k) + 8));
      rdchk("iflag", 4'h4, {5'h11, k[2:0]});
    end
    for (int r = 0; r < 2; r++) begin
      wb(4'h4, 4'h3, 16'ha500, 1'b1);
      wb(4'h0, 4'h3, 16'h5afe, 1'b1);
      wb(4'h4, 4'h3, {10'h297, r[0], 5'h0}, 1'b1);
      if (r == 1) waitfor(mrr, 1'b1);
      if (r == 0) waitfor(por, 1'b1);
      chk("rstkind", {6'h0, r[0], ~r[0]}, {6'h0, mrr, por});
      rdchk("wflag", 4'h4, {2'b11, r[0], 5'h10});
      repeat (62) @(posedge clk);
      rdchk("cont", 4'h0, 8'h01);
    end
    wb(4'h0, 4'h3, 16'h5a00, 1'b1);
    wb(4'h4, 4'h3, 16'ha5c0, 1'b1);
    for (int j = 0; j < 3; j++) begin
      repeat (100) @(posedge clk);
      wb(4'h0, 4'h3, 16'h5a00, 1'b1);
    end
    rdchk("refresh", 4'h4, 8'hc0);
    chk("no_reset", 8'h0, {6'h0, mrr, por});
    wb(4'h4, 4'h3, 16'ha501, 1'b1);
    wb(4'h0, 4'h3, 16'h5afe, 1'b1);
    frq <= 1'b1;
    @(posedge clk);
    frq <= 1'b0;
    repeat (3) @(posedge clk);
    chk("stop", 8'h1, 8'(cstop));
    waitfor(cstop, 1'b0);
    chk("resume", 8'h1, 8'(n < 300));
    rdchk("stab_count", 4'h0, 8'h00);
    rdchk("stab_ctrl", 4'h4, 8'h01);
    wb(4'h0, 4'h3, 16'h5afe, 1'b1);
    stby <= 1'b1;
    @(posedge clk);
    stby <= 1'b0;
    repeat (200) @(posedge clk);
    chk("standby", 8'h1, 8'(cstop));
    wake <= 1'b1;
    waitfor(cstop, 1'b0);
    wake <= 1'b0;
    chk("wakeup", 8'h1, 8'(n < 300));
    wb(4'h4, 4'h3, 16'ha547, 1'b1);
    wb(4'h0, 4'h3, 16'h5a34, 1'b1);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    rdchk("por_count", 4'h0, 8'h00);
    rdchk("por_ctrl", 4'h4, 8'h00);
    test_done();
  end
endmodule // watchdog_interval_timer_bench
